// ==== dv/excseq_chk.sv ====
`timescale 1ns/1ps
// Port-level checks on the sequencer, bound after the module
module excseq_chk (
    // Clock and reset
    input logic        clk,
    input logic        sys_rst,
    // Causes and state
    input logic        illegalInstr,
    input logic [15:0] statusIn,
    input logic [31:0] vectorTableBase,
    // Acknowledge, frame and fetch handshakes
    input logic        iackReq,
    input logic [2:0]  iackLevel,
    input logic        iackDone,
    input logic        frameWrite,
    input logic [31:0] frameAddr,
    input logic [15:0] frameData,
    input logic        frameAck,
    input logic        vectorRead,
    input logic [31:0] vectorAddr,
    input logic        vectorAck,
    input logic [31:0] vectorData,
    // Results
    input logic [15:0] statusOut,
    input logic [15:0] statusCopy,
    input logic [31:0] newPc,
    input logic        resumeFetch,
    input logic        busy,
    input logic        pipelineFlagA
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_cause_taken: assert property (!busy && !resumeFetch && illegalInstr |=> busy)
        else $error("illegal instruction not taken");
    a_super_entry: assert property ($rose(busy) |=> statusOut[13] && statusOut[15:14] == 2'h0)
        else $error("supervisor or trace bits wrong after entry");
    a_status_copy: assert property ($rose(busy) |=> statusCopy == statusIn)
        else $error("status copy differs from status");
    a_mask_irq: assert property ($rose(iackReq) |-> statusOut[10:8] == iackLevel)
        else $error("priority mask not set to level");
    a_iack_hold: assert property (iackReq && !iackDone |=> iackReq && $stable(iackLevel))
        else $error("acknowledge request dropped early");
    a_frame_hold: assert property (frameWrite && !frameAck |=>
        frameWrite && $stable(frameAddr) && $stable(frameData))
        else $error("frame write changed before ack");
    a_step_order: assert property (frameWrite |-> !vectorRead && !iackReq)
        else $error("frame write overlaps other step");
    a_vec_range: assert property (vectorRead |->
        vectorAddr - vectorTableBase < 32'h00000400 && vectorAddr[1:0] == 2'h0)
        else $error("vector address outside table");
    a_fetch_hold: assert property (vectorRead && !vectorAck |=> vectorRead && $stable(vectorAddr))
        else $error("vector read dropped early");
    a_resume_seq: assert property (vectorRead && vectorAck |=>
        newPc == $past(vectorData) ##1 resumeFetch && pipelineFlagA)
        else $error("resume sequence wrong");
endmodule

bind excseq_exception_sequencer excseq_chk chk (.*);

// ==== dv/excseq_exception_sequencer_tb.sv ====
`timescale 1ns/1ps
module excseq_exception_sequencer_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [10:0] cause = 11'h000;
    logic busErrorInput = 1'b0, haltReq = 1'b0, midInstr = 1'b0, instrBoundary = 1'b1;
    logic [3:0] trapNumber = 4'h0;
    logic [7:0] coprocVector = 8'h00;
    logic [15:0] statusIn = 16'h2700;
    logic [31:0] vectorTableBase = 32'h00001000, faultPc = 32'h00000200;
    logic [31:0] masterStackPointer = 32'h00008000, interruptStackPointer = 32'h00004000;
    logic [2:0] reqLevel = 3'h0;
    logic useAuto = 1'b0, slow = 1'b0;
    wire trapReq, conditionalTrapInstr, coprocessorConditionalTrap, boundsCheckInstr;
    wire boundsCheckPairInstr, divideByZero, traceReq, illegalInstr, oddFetchAddr;
    wire privViolation, coprocExcReq, iackReq, iackDone, autovectorRequest, iackBusError;
    wire frameWrite, frameAck, vectorRead, vectorAck, resumeFetch, busy, pipelineFlagA;
    wire [2:0] iackLevel, interruptLevelInputs;
    wire [7:0] iackVector;
    wire [15:0] frameData, statusOut, statusCopy;
    wire [31:0] frameAddr, vectorAddr, vectorData, newPc, masterSpOut, interruptSpOut;
    wire [1:0] seqStatus;
    int fails = 0, testsRun = 0, nWords_q = 0;
    logic [31:0] firstAddr_q, secondAddr_q, fetchAddr_q, rnd = 32'h00007FBB;
    logic [15:0] firstData_q;
    // Vector and frame size per cause; size 0 means not checked
    logic [7:0] vecTab [13] = '{8'h20, 8'h07, 8'h07, 8'h06, 8'h06, 8'h05, 8'h09,
                                8'h04, 8'h03, 8'h08, 8'h00, 8'h02, 8'h00};
    int wTab [13] = '{0, 0, 0, 0, 0, 0, 6, 4, 0, 4, 0, 12, 4};

    assign {coprocExcReq, privViolation, oddFetchAddr, illegalInstr, traceReq, divideByZero,
            boundsCheckPairInstr, boundsCheckInstr, coprocessorConditionalTrap,
            conditionalTrapInstr, trapReq} = cause;

    excseq_exception_sequencer dut (.*);
    excseq_partner partner (.*);

    always #12.5 clk = ~clk;

    // Record frame words and the vector fetch; word count cleared while idle
    always @(posedge clk)
    begin
        if (!busy)
            nWords_q <= 0;
        if (frameWrite && frameAck)
        begin
            if (nWords_q == 0)
                {firstAddr_q, firstData_q} <= {frameAddr, frameData};
            if (nWords_q == 4)
                secondAddr_q <= frameAddr;
            nWords_q <= nWords_q + 1;
        end
        if (vectorRead && vectorAck)
            fetchAddr_q <= vectorAddr;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {1'b0, s[31:1]} ^ (s[0] ? 32'hA3000000 : 32'h00000000);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finalReport;
        $display("fails=%0d testsRun=%0d", fails, testsRun);
        if (fails == 0 && testsRun > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Bounded wait for the resume pulse
    task automatic waitDone;
        int k;
        k = 0;
        do
        begin
            @(posedge clk);
            #1;
            k++;
        end while (resumeFetch !== 1'b1 && k < 3000);
        chk(resumeFetch, 1'b1);
    endtask

    // One exception of cause idx; 11 is bus error, 12 an interrupt
    task automatic run(input int idx);
        logic m, au;
        logic [2:0] lv;
        logic [7:0] vec;
        logic [31:0] ea;
        int words, k;
        rnd = lfsr(rnd);
        m = rnd[3];
        au = rnd[9];
        lv = (rnd[6:4] == 3'h0) ? 3'h1 : rnd[6:4];
        vec = (idx == 0) ? 8'h20 + {4'h0, rnd[7:4]} : (idx == 10) ? rnd[15:8] : vecTab[idx];
        words = (idx == 12) ? (m ? 8 : 4) : wTab[idx];
        if (idx == 12)
            vec = au ? 8'h18 + {5'h00, lv} : 8'h40 | {5'h00, lv};
        @(posedge clk);
        statusIn <= {rnd[31:30], 1'b1, m, 1'b0, (idx == 12) ? 3'h0 : 3'h7, rnd[23:16]};
        vectorTableBase <= {rnd[19:4], 16'h0000};
        {trapNumber, coprocVector, useAuto, slow} <= {rnd[7:4], rnd[15:8], au, rnd[10]};
        @(posedge clk);
        if (idx == 12)
            reqLevel <= lv;
        else if (idx == 11)
            busErrorInput <= 1'b1;
        else
            cause <= 11'h001 << idx;
        @(posedge clk);
        cause <= 11'h000;
        if (idx == 11)
            @(posedge clk);
        busErrorInput <= 1'b0;
        for (k = 0; k < 100 && idx == 12 && iackReq !== 1'b1; k++)
            @(posedge clk) #1;
        if (idx == 12)
        begin
            chk(iackLevel, lv);
            chk(seqStatus, 2'h2);
            @(posedge clk);
            reqLevel <= 3'h0;
        end
        waitDone();
        ea = vectorTableBase + {22'h000000, vec, 2'h0};
        chk(fetchAddr_q, ea);
        chk(newPc, {ea[15:0], 16'h0100});
        chk(firstAddr_q, (m ? masterStackPointer : interruptStackPointer) - 32'h2);
        chk(firstData_q, statusIn);
        if (words != 0)
            chk(nWords_q, words);
        if (idx == 12 && m)
            chk(secondAddr_q, interruptStackPointer - 32'h2);
        if (idx == 12)
            chk({statusOut[13:12], statusOut[10:8]}, {2'h2, lv});
        repeat (6) @(posedge clk);
        if (busy === 1'b1)
            waitDone();
    endtask

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (60000) @(posedge clk);
        fails++;
        finalReport();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        waitDone();
        chk(fetchAddr_q, 32'h00001000);
        chk(nWords_q, 0);
        chk({statusOut[13:12], statusOut[10:8]}, 5'h17);
        for (int i = 0; i < 52; i++)
            run(i % 13);
        // Level below the mask must be ignored
        @(posedge clk);
        statusIn <= 16'h2500;
        reqLevel <= 3'h3;
        repeat (12) @(posedge clk);
        chk(busy, 1'b0);
        reqLevel <= 3'h0;
        // Reset in mid-sequence restarts with the reset vector
        repeat (6) @(posedge clk);
        cause <= 11'h080;
        @(posedge clk);
        cause <= 11'h000;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        waitDone();
        chk(fetchAddr_q, vectorTableBase);
        // Halt shows on the status outputs
        @(posedge clk);
        haltReq <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk(seqStatus, 2'h3);
        finalReport();
    end
endmodule

// ==== dv/excseq_partner.sv ====
`timescale 1ns/1ps
// Interrupt source and acknowledge, frame and fetch responder
module excseq_partner #(
    parameter logic [7:0] VEC_BASE = 8'h40
) (
    // Clock and reset
    input  logic        clk,
    input  logic        sys_rst,
    // Bench controls
    input  logic [2:0]  reqLevel,
    input  logic        useAuto,
    input  logic        slow,
    // Requests from the sequencer
    input  logic        iackReq,
    input  logic [2:0]  iackLevel,
    input  logic        frameWrite,
    input  logic        vectorRead,
    input  logic [31:0] vectorAddr,
    // Answers
    output logic [2:0]  interruptLevelInputs,
    output logic        iackDone,
    output logic [7:0]  iackVector,
    output logic        autovectorRequest,
    output logic        iackBusError,
    output logic        frameAck,
    output logic        vectorAck,
    output logic [31:0] vectorData
);
    logic [2:0] waitCnt_q;

    // Level presented encoded; no spurious cycles modelled
    assign interruptLevelInputs = reqLevel;
    assign iackBusError = 1'b0;

    // One ack at a time; a gap after each so a lingering request is not acked twice
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            waitCnt_q <= 3'h0;
            {iackDone, frameAck, vectorAck, autovectorRequest} <= 4'h0;
            iackVector <= 8'h00;
            vectorData <= 32'h00000000;
        end
        else
        begin
            {iackDone, frameAck, vectorAck, autovectorRequest} <= 4'h0;
            iackVector <= ~iackVector; // Released lines keep changing
            vectorData <= ~vectorData;
            if (waitCnt_q != 3'h0)
                waitCnt_q <= waitCnt_q - 3'h1;
            else if (iackReq)
            begin
                iackDone <= 1'b1;
                autovectorRequest <= useAuto;
                if (!useAuto)
                    iackVector <= VEC_BASE | {5'h00, iackLevel};
                waitCnt_q <= slow ? 3'h5 : 3'h2;
            end
            else if (frameWrite)
            begin
                frameAck <= 1'b1;
                waitCnt_q <= slow ? 3'h5 : 3'h2;
            end
            else if (vectorRead)
            begin
                vectorAck <= 1'b1;
                vectorData <= {vectorAddr[15:0], 16'h0100};
                waitCnt_q <= slow ? 3'h5 : 3'h2;
            end
        end
    end
endmodule

// ==== hw/excseq_defines.vh ====
`ifndef EXCSEQ_DEFINES_VH
`define EXCSEQ_DEFINES_VH
// What this block does
// - Accept interrupts, bus error, reset and internal instruction, address, trace causes.
// - Trap, conditional traps, bounds checks and divide raise exceptions when condition holds.
// - Trace is handled as a very high priority internal interrupt.
// - Illegal instruction, odd fetch address and privilege violation raise exceptions.
// - Every exception runs state change, vector number, stack frame (none on reset), vector fetch in order.
// - First step copies status, sets supervisor bit, clears both trace bits.
// - Reset and interrupt also update the interrupt priority mask in step one.
// - Interrupt vector comes from an interrupt acknowledge read answered by the responder.
// - Coprocessor exceptions take the vector number from the coprocessor response.
// - All other exceptions get their vector number from internal logic.
// - Frame is built on the active supervisor stack, size set by type and point.
// - Interrupt with master bit set clears it, short frame to master then interrupt stack.
// - Reset clears master bit, builds no frame, then fetches the reset vector.
// - Master bit selects master stack for task exceptions and an interrupt's first frame; interrupts end on interrupt stack.
// - Vector address is vector number times four plus vector table base.
// - Final step loads program counter from vector, fetches and resumes execution.
// - Status and pipeline_flag_a outputs mark boundaries, exceptions, halt and pipeline refills.

// Status register bit positions
`define EXCSEQ_SR_T1      15
`define EXCSEQ_SR_T0      14
`define EXCSEQ_SR_S       13
`define EXCSEQ_SR_M       12
`define EXCSEQ_SR_IPM_HI  10
`define EXCSEQ_SR_IPM_LO  8
`define EXCSEQ_SR_RESET   16'h2700

// Cause codes, lowest code wins
`define EXCSEQ_C_RESET    4'h0
`define EXCSEQ_C_BUSERR   4'h1
`define EXCSEQ_C_ODDADDR  4'h2
`define EXCSEQ_C_TRACE    4'h3
`define EXCSEQ_C_IRQ      4'h4
`define EXCSEQ_C_ILLEGAL  4'h5
`define EXCSEQ_C_PRIV     4'h6
`define EXCSEQ_C_INSTR    4'h7
`define EXCSEQ_C_COPROC   4'h8
`define EXCSEQ_C_NONE     4'hF

// Internal vector numbers
`define EXCSEQ_V_RESET    8'h00
`define EXCSEQ_V_BUSERR   8'h02
`define EXCSEQ_V_ODDADDR  8'h03
`define EXCSEQ_V_ILLEGAL  8'h04
`define EXCSEQ_V_PRIV     8'h08
`define EXCSEQ_V_TRACE    8'h09
`define EXCSEQ_V_SPUR     8'h18
`define EXCSEQ_V_AUTO     8'h18
`define EXCSEQ_V_UNINIT   8'h0F

// Frame sizes in words
`define EXCSEQ_FRAME_SHORT 4'h4
`define EXCSEQ_FRAME_SIX   4'h6
`define EXCSEQ_FRAME_BUS   4'hC

// Status output codes
`define EXCSEQ_ST_IDLE    2'h0
`define EXCSEQ_ST_BOUND   2'h1
`define EXCSEQ_ST_EXC     2'h2
`define EXCSEQ_ST_HALT    2'h3

`endif

// ==== hw/excseq_exception_sequencer.v ====
`timescale 1ns/1ps
`include "excseq_defines.vh"
// Exception processing sequencer
module excseq_exception_sequencer (
    // Clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // External causes (pins)
    input  wire [2:0]  interruptLevelInputs,
    input  wire        busErrorInput,
    // Internal causes from the execution unit, one-cycle pulses; instrBoundary, midInstr and haltReq are levels
    input  wire        trapReq,
    input  wire        conditionalTrapInstr,
    input  wire        coprocessorConditionalTrap,
    input  wire        boundsCheckInstr,
    input  wire        boundsCheckPairInstr,
    input  wire        divideByZero,
    input  wire [3:0]  trapNumber,
    input  wire        traceReq,
    input  wire        illegalInstr,
    input  wire        oddFetchAddr,
    input  wire        privViolation,
    input  wire        coprocExcReq,
    input  wire [7:0]  coprocVector,
    input  wire        instrBoundary,
    input  wire        midInstr,
    input  wire        haltReq,
    // Processor state
    input  wire [15:0] statusIn,
    input  wire [31:0] vectorTableBase,
    input  wire [31:0] masterStackPointer,
    input  wire [31:0] interruptStackPointer,
    input  wire [31:0] faultPc,
    // Interrupt acknowledge cycle
    output reg         iackReq,
    output reg  [2:0]  iackLevel,
    input  wire        iackDone,
    input  wire [7:0]  iackVector,
    input  wire        autovectorRequest,
    input  wire        iackBusError,
    // Stack frame writes
    output reg         frameWrite,
    output reg  [31:0] frameAddr,
    output reg  [15:0] frameData,
    input  wire        frameAck,
    // Vector fetch
    output reg         vectorRead,
    output reg  [31:0] vectorAddr,
    input  wire        vectorAck,
    input  wire [31:0] vectorData,
    // Results
    output reg  [15:0] statusOut,
    output reg  [15:0] statusCopy,
    output reg  [31:0] newPc,
    output reg         resumeFetch,
    output reg  [31:0] masterSpOut,
    output reg  [31:0] interruptSpOut,
    output reg         busy,
    // Pipeline status
    output reg  [1:0]  seqStatus,
    output reg         pipelineFlagA
);
    localparam S_IDLE  = 3'h0;
    localparam S_STATE = 3'h1;
    localparam S_VECT  = 3'h2;
    localparam S_FRAME = 3'h3;
    localparam S_FETCH = 3'h4;
    localparam S_DONE  = 3'h5;

    wire [2:0] ipl;
    wire       bus_error_input;

    // Pins from outside the clock domain
    excseq_sync3 #(.W(4)) uSync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pinIn   ({interruptLevelInputs, busErrorInput}),
        .syncOut ({ipl, bus_error_input})
    );

    reg [2:0]  state_q;
    reg [3:0]  cause_q;
    reg [7:0]  vec_q;
    reg [3:0]  words_q;
    reg [3:0]  wcnt_q;
    reg        dual_q;
    reg        second_q;
    reg [31:0] sp_q;
    reg [2:0]  irqLvl_q;
    reg        rstPend_q;
    reg        berrPend_q;
    reg [7:0]  instrVec_d;
    reg [3:0]  cause_d;
    wire       irqPending;
    wire       instrExc;
    wire [2:0] ipm;

    assign ipm = statusIn[`EXCSEQ_SR_IPM_HI:`EXCSEQ_SR_IPM_LO];
    // Level 7 is not maskable
    assign irqPending = (ipl == 3'h7) || (ipl > ipm);
    assign instrExc = trapReq | conditionalTrapInstr | coprocessorConditionalTrap
                    | boundsCheckInstr | boundsCheckPairInstr | divideByZero;

    // Instruction trap vector numbers
    always @*
    begin
        instrVec_d = 8'h20 + {4'h0, trapNumber};
        if (divideByZero)
            instrVec_d = 8'h05;
        else if (boundsCheckInstr | boundsCheckPairInstr)
            instrVec_d = 8'h06;
        else if (conditionalTrapInstr | coprocessorConditionalTrap)
            instrVec_d = 8'h07;
    end

    // Cause priority; trace outranks interrupts and instruction traps
    always @*
    begin
        cause_d = `EXCSEQ_C_NONE;
        if (rstPend_q)
            cause_d = `EXCSEQ_C_RESET;
        else if (berrPend_q)
            cause_d = `EXCSEQ_C_BUSERR;
        else if (oddFetchAddr)
            cause_d = `EXCSEQ_C_ODDADDR;
        else if (traceReq && instrBoundary)
            cause_d = `EXCSEQ_C_TRACE;
        else if (irqPending && instrBoundary)
            cause_d = `EXCSEQ_C_IRQ;
        else if (illegalInstr)
            cause_d = `EXCSEQ_C_ILLEGAL;
        else if (privViolation)
            cause_d = `EXCSEQ_C_PRIV;
        else if (instrExc)
            cause_d = `EXCSEQ_C_INSTR;
        else if (coprocExcReq)
            cause_d = `EXCSEQ_C_COPROC;
    end

    // Main sequencer
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q        <= S_IDLE;
            cause_q        <= `EXCSEQ_C_NONE;
            vec_q          <= 8'h00;
            words_q        <= 4'h0;
            wcnt_q         <= 4'h0;
            dual_q         <= 1'b0;
            second_q       <= 1'b0;
            sp_q           <= 32'h0;
            irqLvl_q       <= 3'h0;
            rstPend_q      <= 1'b1;
            berrPend_q     <= 1'b0;
            iackReq        <= 1'b0;
            iackLevel      <= 3'h0;
            frameWrite     <= 1'b0;
            frameAddr      <= 32'h0;
            frameData      <= 16'h0;
            vectorRead     <= 1'b0;
            vectorAddr     <= 32'h0;
            statusOut      <= `EXCSEQ_SR_RESET;
            statusCopy     <= 16'h0;
            newPc          <= 32'h0;
            resumeFetch    <= 1'b0;
            masterSpOut    <= 32'h0;
            interruptSpOut <= 32'h0;
            busy           <= 1'b0;
        end
        else
        begin
            resumeFetch <= 1'b0;
            // Bus error is caught even mid-sequence; set wins over the clear
            if (bus_error_input)
                berrPend_q <= 1'b1;
            case (state_q)
                S_IDLE:
                begin
                    masterSpOut    <= masterStackPointer;
                    interruptSpOut <= interruptStackPointer;
                    if (cause_d != `EXCSEQ_C_NONE)
                    begin
                        cause_q  <= cause_d;
                        irqLvl_q <= ipl;
                        busy     <= 1'b1;
                        state_q  <= S_STATE;
                        if (cause_d == `EXCSEQ_C_BUSERR && !bus_error_input)
                            berrPend_q <= 1'b0;
                        rstPend_q <= 1'b0;
                        case (cause_d)
                            `EXCSEQ_C_RESET:   vec_q <= `EXCSEQ_V_RESET;
                            `EXCSEQ_C_BUSERR:  vec_q <= `EXCSEQ_V_BUSERR;
                            `EXCSEQ_C_ODDADDR: vec_q <= `EXCSEQ_V_ODDADDR;
                            `EXCSEQ_C_TRACE:   vec_q <= `EXCSEQ_V_TRACE;
                            `EXCSEQ_C_ILLEGAL: vec_q <= `EXCSEQ_V_ILLEGAL;
                            `EXCSEQ_C_PRIV:    vec_q <= `EXCSEQ_V_PRIV;
                            `EXCSEQ_C_INSTR:   vec_q <= instrVec_d;
                            `EXCSEQ_C_COPROC:  vec_q <= coprocVector;
                            default:           vec_q <= `EXCSEQ_V_UNINIT;
                        endcase
                    end
                end
                S_STATE:
                begin
                    // Copy first, then alter the control bits
                    statusCopy <= statusIn;
                    statusOut  <= statusIn;
                    statusOut[`EXCSEQ_SR_S]  <= 1'b1;
                    statusOut[`EXCSEQ_SR_T1] <= 1'b0;
                    statusOut[`EXCSEQ_SR_T0] <= 1'b0;
                    if (cause_q == `EXCSEQ_C_RESET)
                        statusOut[`EXCSEQ_SR_IPM_HI:`EXCSEQ_SR_IPM_LO] <= 3'h7;
                    else if (cause_q == `EXCSEQ_C_IRQ)
                        statusOut[`EXCSEQ_SR_IPM_HI:`EXCSEQ_SR_IPM_LO] <= irqLvl_q;
                    if (cause_q == `EXCSEQ_C_IRQ)
                    begin
                        iackReq   <= 1'b1;
                        iackLevel <= irqLvl_q;
                    end
                    state_q <= S_VECT;
                end
                S_VECT:
                begin
                    if (cause_q != `EXCSEQ_C_IRQ)
                        state_q <= S_FRAME;
                    else if (iackDone)
                    begin
                        iackReq <= 1'b0;
                        if (iackBusError)
                            vec_q <= `EXCSEQ_V_SPUR;
                        else if (autovectorRequest)
                            vec_q <= `EXCSEQ_V_AUTO + {5'h00, irqLvl_q};
                        else
                            vec_q <= iackVector;
                        state_q <= S_FRAME;
                    end
                    // Frame size and stack choice
                    if (cause_q == `EXCSEQ_C_BUSERR)
                        words_q <= `EXCSEQ_FRAME_BUS;
                    else if (cause_q == `EXCSEQ_C_INSTR || cause_q == `EXCSEQ_C_TRACE || midInstr)
                        words_q <= `EXCSEQ_FRAME_SIX;
                    else
                        words_q <= `EXCSEQ_FRAME_SHORT;
                    dual_q   <= (cause_q == `EXCSEQ_C_IRQ) && statusIn[`EXCSEQ_SR_M];
                    second_q <= 1'b0;
                    wcnt_q   <= 4'h0;
                    if (cause_q == `EXCSEQ_C_IRQ && !statusIn[`EXCSEQ_SR_M])
                        sp_q <= interruptStackPointer;
                    else if (statusIn[`EXCSEQ_SR_M])
                        sp_q <= masterStackPointer;
                    else
                        sp_q <= interruptStackPointer;
                end
                S_FRAME:
                begin
                    if (cause_q == `EXCSEQ_C_RESET)
                    begin
                        // No frame on reset
                        statusOut[`EXCSEQ_SR_M] <= 1'b0;
                        state_q <= S_FETCH;
                    end
                    else if (!frameWrite)
                    begin
                        frameWrite <= 1'b1;
                        frameAddr  <= sp_q - {27'h0, wcnt_q, 1'b0} - 32'h2;
                        case (wcnt_q)
                            4'h0:    frameData <= statusCopy;
                            4'h1:    frameData <= faultPc[31:16];
                            4'h2:    frameData <= faultPc[15:0];
                            4'h3:    frameData <= {6'h00, vec_q, 2'b00};
                            default: frameData <= 16'h0000;
                        endcase
                    end
                    else if (frameAck)
                    begin
                        frameWrite <= 1'b0;
                        if (wcnt_q + 4'h1 != words_q)
                            wcnt_q <= wcnt_q + 4'h1;
                        else
                        begin
                            wcnt_q <= 4'h0;
                            if (!second_q)
                            begin
                                if (sp_q == masterStackPointer)
                                    masterSpOut <= sp_q - {27'h0, words_q, 1'b0};
                                else
                                    interruptSpOut <= sp_q - {27'h0, words_q, 1'b0};
                            end
                            else
                                interruptSpOut <= sp_q - {27'h0, words_q, 1'b0};
                            if (dual_q && !second_q)
                            begin
                                // Same short frame again on the interrupt stack
                                second_q <= 1'b1;
                                sp_q     <= interruptStackPointer;
                                statusOut[`EXCSEQ_SR_M] <= 1'b0;
                            end
                            else
                                state_q <= S_FETCH;
                        end
                    end
                end
                S_FETCH:
                begin
                    if (!vectorRead)
                    begin
                        vectorRead <= 1'b1;
                        vectorAddr <= vectorTableBase + {22'h0, vec_q, 2'b00};
                    end
                    else if (vectorAck)
                    begin
                        vectorRead <= 1'b0;
                        newPc      <= vectorData;
                        state_q    <= S_DONE;
                    end
                end
                S_DONE:
                begin
                    resumeFetch <= 1'b1;
                    busy        <= 1'b0;
                    state_q     <= S_IDLE;
                end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end

    // Pipeline status outputs follow the sequencer, not bus activity
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            seqStatus     <= `EXCSEQ_ST_IDLE;
            pipelineFlagA <= 1'b0;
        end
        else
        begin
            if (haltReq)
                seqStatus <= `EXCSEQ_ST_HALT;
            else if (state_q != S_IDLE)
                seqStatus <= `EXCSEQ_ST_EXC;
            else if (instrBoundary)
                seqStatus <= `EXCSEQ_ST_BOUND;
            else
                seqStatus <= `EXCSEQ_ST_IDLE;
            pipelineFlagA <= (state_q == S_DONE);
        end
    end
endmodule

// ==== hw/excseq_sync3.v ====
`timescale 1ns/1ps
// Three-stage pin synchroniser; output moves when stages two and three agree
module excseq_sync3 #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clk,
    input  wire         sys_rst,
    // Data
    input  wire [W-1:0] pinIn,
    output reg  [W-1:0] syncOut
);
    reg [W-1:0] stage1Q;
    reg [W-1:0] stage2Q;
    reg [W-1:0] stage3Q;

    // Stage one feeds only stage two, never any logic
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stage1Q <= {W{1'b0}};
            stage2Q <= {W{1'b0}};
            stage3Q <= {W{1'b0}};
            syncOut <= {W{1'b0}};
        end
        else
        begin
            stage1Q <= pinIn;
            stage2Q <= stage1Q;
            stage3Q <= stage2Q;
            if (stage2Q == stage3Q)
                syncOut <= stage3Q;
        end
    end
endmodule
